//--- inc/tsrr_pkg.sv
// Operation
// RULE_01 - Control bit 7 picks trimmed level when clear, software override code when set.
// RULE_02 - Override code bits 6:3 steps 0.1 V; 5 V mode spans 3.6 to 5.1 V.
// RULE_03 - Bits 2:0 pick measured rail: main, analog, digital, RF, AM; 101-111 reserved.
// RULE_04 - Regulator readback shows trimmed code in bits 7:4; bits 3:0 read zero.
// RULE_05 - AM strength peak sits in bits 7:4, held until reception start or clear.
// RULE_06 - PM strength peak sits in bits 3:0, held until reception start or clear.
// RULE_07 - Strength codes rise with amplitude, so the peak is the largest code seen.
// RULE_08 - Driver timing readback bits 7:4 give transient ratio; bit 3 reads zero.
// RULE_09 - Driver speed code: slow, medium slow, nominal, medium fast, top bit set fast.
// RULE_10 - Driver timing and regulator readback sit at 2Bh and 2Ch of space B.
// RULE_11 - Host writes to read-only registers are ignored and change nothing.
package tsrr_pkg;

    localparam int unsigned IDX_W = 9;
    localparam logic [IDX_W-1:0] SPACE_B_BASE = 9'h100;
    localparam logic [IDX_W-1:0] IDX_REG_CTRL = 9'h02C;
    localparam logic [IDX_W-1:0] IDX_STRENGTH = 9'h02D;
    localparam logic [IDX_W-1:0] IDX_DRV_TIMING = SPACE_B_BASE | 9'h02B;
    localparam logic [IDX_W-1:0] IDX_REG_READBACK = SPACE_B_BASE | 9'h02C;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int unsigned CTRL_SRC_BIT = 7;
    localparam int unsigned CTRL_LEVEL_LSB = 3;
    localparam int unsigned CTRL_RAIL_LSB = 0;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [3:0] STRENGTH_FLOOR = 4'h0;

    localparam logic [12:0] LEVEL_STEP_MV = 13'h0064;
    localparam logic [12:0] LEVEL_BASE_5V_MV = 13'h0E10;
    localparam logic [12:0] LEVEL_BASE_3V3_MV = 13'h076C;

    typedef enum logic [2:0] {
        RAIL_MAIN = 3'h0,
        RAIL_ANALOG = 3'h1,
        RAIL_DIGITAL = 3'h2,
        RAIL_RF = 3'h3,
        RAIL_AM = 3'h4
    } tsrr_rail_t;

    typedef enum logic [4:0] {
        SPEED_SLOW = 5'h01,
        SPEED_MED_SLOW = 5'h02,
        SPEED_NOMINAL = 5'h04,
        SPEED_MED_FAST = 5'h08,
        SPEED_FAST = 5'h10
    } tsrr_speed_t;

    typedef struct packed {
        logic [3:0] ratio;
        logic [2:0] speed;
    } tsrr_timing_t;

    typedef struct packed {
        logic [3:0] am;
        logic [3:0] pm;
    } tsrr_strength_t;

endpackage

//--- rtl/tsrr_peak_hold.sv
`timescale 1ns/10ps
module tsrr_peak_hold (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic sample_valid_in,
    input wire logic [3:0] sample_code_in,
    input wire logic restart_in,
    output logic [3:0] peak_out
);
    import tsrr_pkg::*;

    logic [3:0] next_peak;
    wire sample_higher = sample_code_in > peak_out;

    // A sample arriving with a restart starts the new peak
    assign next_peak = sample_valid_in ?
        ((restart_in || sample_higher) ? sample_code_in : peak_out) :
        (restart_in ? STRENGTH_FLOOR : peak_out);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            peak_out <= STRENGTH_FLOOR;
        end else begin
            peak_out <= next_peak;
        end
    end

endmodule

//--- rtl/tsrr_regs.sv
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
module tsrr_regs (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic five_volt_mode_in,
    input wire logic trim_done_in,
    input wire logic [3:0] trim_code_in,
    input wire tsrr_pkg::tsrr_timing_t timing_in,
    input wire logic strength_valid_in,
    input wire tsrr_pkg::tsrr_strength_t strength_sample_in,
    input wire logic rx_start_in,
    input wire logic clear_strength_in,
    output logic regulator_override_out,
    output logic [3:0] regulator_code_out,
    output logic [12:0] regulator_mv_out,
    output logic [2:0] rail_select_out,
    output logic rail_valid_out,
    output tsrr_pkg::tsrr_speed_t driver_speed_out,
    output logic [3:0] driver_ratio_out
);
    import tsrr_pkg::*;

    // Bus decode
    logic wr_pend;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0] ctrl;
    logic [3:0] trim_level;
    tsrr_timing_t timing_q;
    logic [3:0] peak [2];

    wire [IDX_W-1:0] addr_idx = haddr_in[IDX_W+1:2];
    wire addr_ok = haddr_in[31:IDX_W+2] == '0;
    wire bus_take = hsel_in && htrans_in[1] && hready_in;
    wire rd_take = bus_take && !hwrite_in;

    // Ctrl write only
    // RULE_11 read-only protected
    wire ctrl_write = wr_pend && (wr_idx == IDX_REG_CTRL);

    // Write forward
    wire [7:0] next_ctrl = ctrl_write ? hwdata_in[7:0] : ctrl;

    wire hit_ctrl = addr_ok && (addr_idx == IDX_REG_CTRL);
    wire hit_strength = addr_ok && (addr_idx == IDX_STRENGTH);
    // RULE_10 space B offsets
    wire hit_timing = addr_ok && (addr_idx == IDX_DRV_TIMING);
    wire hit_readback = addr_ok && (addr_idx == IDX_REG_READBACK);

    // RULE_04 readback layout
    wire [7:0] readback_byte = {trim_level, 4'h0};
    // RULE_08 ratio and reserved
    wire [7:0] timing_byte = {timing_q.ratio, 1'b0, timing_q.speed};
    // RULE_05 AM upper nibble
    // RULE_06 PM lower nibble
    wire [7:0] strength_byte = {peak[0], peak[1]};

    wire [7:0] rd_byte = hit_ctrl ? next_ctrl :
        hit_strength ? strength_byte :
        hit_timing ? timing_byte :
        hit_readback ? readback_byte : 8'h00;

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_pend <= 1'b0;
            wr_idx <= '0;
        end else begin
            wr_pend <= bus_take && hwrite_in && addr_ok;
            wr_idx <= addr_idx;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata_out <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Control fields
    wire ctrl_override = ctrl[CTRL_SRC_BIT];
    wire [3:0] ctrl_level = ctrl[CTRL_LEVEL_LSB +: 4];
    wire [2:0] ctrl_rail = ctrl[CTRL_RAIL_LSB +: 3];

    // Trim result capture
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            trim_level <= LEVEL_RESET;
        end else if (trim_done_in) begin
            trim_level <= trim_code_in;
        end
    end

    // Timing snapshot
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            timing_q <= '0;
        end else begin
            timing_q <= timing_in;
        end
    end

    // RULE_01 source select
    wire [3:0] next_code = ctrl_override ? ctrl_level : trim_level;

    // RULE_02 level in millivolts
    wire [12:0] level_base = five_volt_mode_in ? LEVEL_BASE_5V_MV : LEVEL_BASE_3V3_MV;
    wire [12:0] level_span = 13'(next_code) * LEVEL_STEP_MV;
    wire [12:0] next_mv = level_base + level_span;

    // RULE_03 reserved rail codes
    wire next_rail_valid = ctrl_rail <= RAIL_AM;

    // RULE_09 speed decode
    tsrr_speed_t next_speed;
    assign next_speed = timing_q.speed[2] ? SPEED_FAST :
        (timing_q.speed[1:0] == 2'h3) ? SPEED_MED_FAST :
        (timing_q.speed[1:0] == 2'h2) ? SPEED_NOMINAL :
        (timing_q.speed[1:0] == 2'h1) ? SPEED_MED_SLOW : SPEED_SLOW;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            regulator_override_out <= 1'b0;
            regulator_code_out <= LEVEL_RESET;
            regulator_mv_out <= LEVEL_BASE_3V3_MV;
            rail_select_out <= RAIL_MAIN;
            rail_valid_out <= 1'b1;
        end else begin
            regulator_override_out <= ctrl_override;
            regulator_code_out <= next_code;
            regulator_mv_out <= next_mv;
            rail_select_out <= ctrl_rail;
            rail_valid_out <= next_rail_valid;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            driver_speed_out <= SPEED_SLOW;
            driver_ratio_out <= 4'h0;
        end else begin
            driver_speed_out <= next_speed;
            driver_ratio_out <= timing_q.ratio;
        end
    end

    // Peak capture per channel
    wire strength_restart = rx_start_in || clear_strength_in;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_peak
            // RULE_07 monotonic peak
            tsrr_peak_hold u_peak (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .sample_valid_in(strength_valid_in),
                .sample_code_in(ch == 0 ? strength_sample_in.am : strength_sample_in.pm),
                .restart_in(strength_restart),
                .peak_out(peak[ch])
            );
        end
    endgenerate

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    a_source_select: assert property ( // RULE_01
        ##1 regulator_code_out ==
            ($past(ctrl[CTRL_SRC_BIT]) ? $past(ctrl[CTRL_LEVEL_LSB +: 4]) : $past(trim_level))
    ) else $error("regulator code not from selected source");

    a_level_top: assert property ( // RULE_02
        five_volt_mode_in && next_code == 4'hF
        |=> regulator_mv_out == LEVEL_BASE_5V_MV + 13'(15) * LEVEL_STEP_MV
    ) else $error("top override level not 5.1 V");

    // Outputs load their computed values on the first edge after release
    a_level_bottom: assert property ( // RULE_02
        !reset_in && five_volt_mode_in && next_code == 4'h0
        |=> regulator_mv_out == LEVEL_BASE_5V_MV
    ) else $error("bottom override level not 3.6 V");

    a_rail_reserved: assert property ( // RULE_03
        ##1 rail_valid_out == ($past(ctrl[2:0]) < 3'h5)
    ) else $error("rail valid flag wrong");

    a_trim_capture: assert property ( // RULE_04
        trim_done_in ##1 rd_take && hit_readback
        |=> hrdata_out == {24'h00_0000, $past(trim_code_in, 2), 4'h0}
    ) else $error("regulator readback lost trim result");

    a_am_hold: assert property ( // RULE_05
        !strength_valid_in && !strength_restart |=> $stable(peak[0])
    ) else $error("AM peak changed without cause");

    a_pm_clear: assert property ( // RULE_06
        clear_strength_in && !strength_valid_in |=> peak[1] == STRENGTH_FLOOR
    ) else $error("PM peak not cleared");

    a_peak_rise: assert property ( // RULE_07
        strength_valid_in && !strength_restart |=> peak[0] >= $past(peak[0])
            && peak[0] >= $past(strength_sample_in.am)
    ) else $error("AM peak not monotonic");

    a_timing_read: assert property ( // RULE_08
        rd_take && hit_timing |=> hrdata_out[7:4] == $past(timing_q.ratio)
            && hrdata_out[3] == 1'b0
    ) else $error("driver ratio readback wrong");

    a_speed_fast: assert property ( // RULE_09
        timing_q.speed[2] |=> driver_speed_out == SPEED_FAST
    ) else $error("top speed bit not fast");

    a_space_split: assert property ( // RULE_10
        rd_take && addr_ok && addr_idx == (SPACE_B_BASE | IDX_REG_CTRL)
        |=> hrdata_out[3:0] == 4'h0
    ) else $error("space B 2Ch returned control bits");

    a_ro_ignore: assert property ( // RULE_11
        wr_pend && wr_idx != IDX_REG_CTRL |=> $stable(ctrl)
    ) else $error("write to read-only changed control");

    a_ctrl_hold: assert property ( // RULE_11
        !ctrl_write
        |=> $stable(ctrl)
    ) else $error("control changed without a write");

    a_ctrl_load: assert property ( // RULE_01
        ctrl_write
        |=> ctrl == $past(hwdata_in[7:0])
    ) else $error("control write not stored");

    a_override_follow: assert property ( // RULE_01
        ##1 regulator_override_out == $past(ctrl[CTRL_SRC_BIT])
    ) else $error("override output not from control bit");

    a_level_3v3: assert property ( // RULE_02
        !reset_in && !five_volt_mode_in && next_code == 4'hF
        |=> regulator_mv_out == LEVEL_BASE_3V3_MV + 13'(15) * LEVEL_STEP_MV
    ) else $error("top level in 3.3 V mode not 3.4 V");

    a_rail_follow: assert property ( // RULE_03
        ##1 rail_select_out == $past(ctrl[CTRL_RAIL_LSB +: 3])
    ) else $error("rail select output not from control");

    a_readback_low: assert property ( // RULE_04
        rd_take && hit_readback
        |=> hrdata_out[3:0] == 4'h0
    ) else $error("regulator readback low bits not zero");

    a_trim_hold: assert property ( // RULE_04
        !trim_done_in
        |=> $stable(trim_level)
    ) else $error("trim result changed without capture");

    a_strength_read: assert property ( // RULE_05
        rd_take && hit_strength
        |=> hrdata_out[7:0] == {$past(peak[0]), $past(peak[1])}
    ) else $error("strength readback fields misplaced");

    a_am_restart: assert property ( // RULE_05
        strength_restart && !strength_valid_in
        |=> peak[0] == STRENGTH_FLOOR
    ) else $error("AM peak not restarted");

    a_pm_hold: assert property ( // RULE_06
        !strength_valid_in && !strength_restart
        |=> $stable(peak[1])
    ) else $error("PM peak changed without cause");

    a_pm_restart: assert property ( // RULE_06
        strength_restart && !strength_valid_in
        |=> peak[1] == STRENGTH_FLOOR
    ) else $error("PM peak not restarted");

    a_pm_rise: assert property ( // RULE_07
        strength_valid_in && !strength_restart
        |=> peak[1] >= $past(peak[1]) && peak[1] >= $past(strength_sample_in.pm)
    ) else $error("PM peak not monotonic");

    a_ratio_follow: assert property ( // RULE_08
        ##1 driver_ratio_out == $past(timing_q.ratio)
    ) else $error("driver ratio output wrong");

    a_timing_speed: assert property ( // RULE_09
        rd_take && hit_timing
        |=> hrdata_out[2:0] == $past(timing_q.speed)
    ) else $error("driver speed readback wrong");

    a_speed_slow: assert property ( // RULE_09
        timing_q.speed == 3'h0
        |=> driver_speed_out == SPEED_SLOW
    ) else $error("speed code 0 not slow");

    a_speed_medslow: assert property ( // RULE_09
        timing_q.speed == 3'h1
        |=> driver_speed_out == SPEED_MED_SLOW
    ) else $error("speed code 1 not medium slow");

    a_speed_nominal: assert property ( // RULE_09
        timing_q.speed == 3'h2
        |=> driver_speed_out == SPEED_NOMINAL
    ) else $error("speed code 2 not nominal");

    a_speed_medfast: assert property ( // RULE_09
        timing_q.speed == 3'h3
        |=> driver_speed_out == SPEED_MED_FAST
    ) else $error("speed code 3 not medium fast");

    a_unmapped_zero: assert property ( // RULE_10
        rd_take && !(hit_ctrl || hit_strength || hit_timing || hit_readback)
        |=> hrdata_out == 32'h0000_0000
    ) else $error("unmapped read not zero");

    c_override_write: cover property (
        ctrl_write && hwdata_in[CTRL_SRC_BIT] ##1 regulator_override_out == 1'b0
    );

    c_peak_restart: cover property (
        strength_valid_in ##1 rx_start_in ##1 strength_valid_in
    );

    c_back_to_back: cover property (
        ctrl_write && rd_take && hit_ctrl
    );

    c_trim_readback: cover property (
        trim_done_in ##1 rd_take && hit_readback
    );

    c_fast_speed: cover property (
        timing_q.speed[2] ##1 driver_speed_out == SPEED_FAST
    );

endmodule

//--- bench/tsrr_host.sv
`timescale 1ns/10ps
module tsrr_host (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0;
    end
    // Single word transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel_out <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out <= a;
        hwrite_out <= w;
        hwdata_out <= ~hwdata_out;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'h0;
        hwdata_out <= d;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        r = hrdata_in;
    endtask
endmodule

//--- bench/test_transceiver_status_regulator_regs.sv
`timescale 1ns/10ps
module test_transceiver_status_regulator_regs;
    import tsrr_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic five_v = 1'b1;
    logic trim_done = 1'b0;
    logic s_valid = 1'b0;
    logic rx_start = 1'b0;
    logic clr = 1'b0;
    logic [3:0] trim_code = 4'h0;
    tsrr_timing_t timing = '0;
    tsrr_strength_t sample = '0;
    logic hready, hsel, hwrite, ovr, rail_ok, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize, rail;
    logic [3:0] code, ratio;
    logic [12:0] mv;
    logic [31:0] haddr, hwdata, hrdata, rd;
    tsrr_speed_t speed;
    int miscompares = 0;
    int n_compared = 0;
    always #5 clk_in = ~clk_in;
    tsrr_host host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hwdata_out(hwdata));
    tsrr_regs dut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .five_volt_mode_in(five_v), .trim_done_in(trim_done), .trim_code_in(trim_code),
        .timing_in(timing), .strength_valid_in(s_valid), .strength_sample_in(sample),
        .rx_start_in(rx_start), .clear_strength_in(clr), .regulator_override_out(ovr),
        .regulator_code_out(code), .regulator_mv_out(mv), .rail_select_out(rail),
        .rail_valid_out(rail_ok), .driver_speed_out(speed), .driver_ratio_out(ratio));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd);
    endtask
    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd);
        chk(what, rd, exp);
    endtask
    task automatic pulse_s(input logic [7:0] v);
        sample <= v;
        s_valid <= 1'b1;
        tick(1);
        s_valid <= 1'b0;
        tick(1);
    endtask
    task automatic t_ctrl;
        logic [3:0] c;
        rdc("ctrl reset", 32'hB0, 32'h0);
        for (int r = 0; r < 8; r++) begin
            c = {r[2:0], r[0]};
            wr(32'hB0, {24'h0, 1'b1, c, r[2:0]});
            tick(2);
            chk("override", 32'(ovr), 32'h1);
            chk("code", 32'(code), 32'(c));
            chk("mv", 32'(mv), 32'h0E10 + 32'h64 * 32'(c));
            chk("rail", 32'(rail), 32'(r));
            chk("rail valid", 32'(rail_ok), 32'(r < 5));
            rdc("ctrl", 32'hB0, {24'h0, 1'b1, c, r[2:0]});
        end
        five_v <= 1'b0;
        tick(2);
        chk("mv 3.3 V", 32'(mv), 32'h0D48);
        five_v <= 1'b1;
        $display("test ctrl done");
    endtask
    task automatic t_trim;
        wr(32'hB0, 32'h0);
        trim_code <= 4'h9;
        trim_done <= 1'b1;
        tick(1);
        trim_done <= 1'b0;
        trim_code <= 4'h2;
        rdc("readback", 32'h4B0, 32'h90);
        tick(1);
        chk("trim code", 32'(code), 32'h9);
        chk("override off", 32'(ovr), 32'h0);
        rdc("ctrl space A", 32'hB0, 32'h0);
        $display("test trim done");
    endtask
    task automatic t_timing;
        for (int s = 0; s < 8; s++) begin
            timing <= '{ratio: 4'(s + 8), speed: 3'(s)};
            tick(3);
            chk("speed", 32'(speed), s > 3 ? 32'h10 : 32'h1 << s);
            chk("ratio", 32'(ratio), 32'(s + 8));
            rdc("timing rb", 32'h4AC, 32'((s + 8) * 16 + s));
        end
        $display("test timing done");
    endtask
    task automatic t_strength;
        pulse_s(8'h53);
        rdc("peak", 32'hB4, 32'h53);
        pulse_s(8'h27);
        rdc("peak per field", 32'hB4, 32'h57);
        rx_start <= 1'b1;
        tick(1);
        rx_start <= 1'b0;
        rdc("restart", 32'hB4, 32'h0);
        pulse_s(8'hC1);
        rdc("peak new", 32'hB4, 32'hC1);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        rdc("clear", 32'hB4, 32'h0);
        $display("test strength done");
    endtask
    task automatic t_ro;
        pulse_s(8'h6A);
        wr(32'hB4, 32'hFF);
        wr(32'h4AC, 32'hFF);
        wr(32'h4B0, 32'hFF);
        rdc("peak kept", 32'hB4, 32'h6A);
        rdc("timing kept", 32'h4AC, 32'hF7);
        rdc("trim kept", 32'h4B0, 32'h90);
        rdc("ctrl kept", 32'hB0, 32'h0);
        rdc("unmapped", 32'hFC, 32'h0);
        chk("okay response", 32'(hresp), 32'h0);
        $display("test read-only done");
    endtask
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        tick(10);
        reset_in <= 1'b0;
        tick(1);
        t_ctrl;
        t_trim;
        t_timing;
        t_strength;
        t_ro;
        end_sim;
    end
    // Hang guard, far beyond the roughly 150 cycles needed
    initial begin
        tick(5000);
        miscompares++;
        end_sim;
    end
endmodule
